/* tb.sv */
// self-checking bench for usbif_core over ahb-lite, host stand-in on events
// assumes package, core, host model and checker compiled before this file
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb import usbif_pkg::*;;
  localparam int RC = 3;
  localparam int SC = 10;
  localparam logic [31:0] A_EN = {24'h00_0000, OFS_IRQ_ENABLE};
  localparam logic [31:0] A_ST = {24'h00_0000, OFS_EVENT_STATUS};
  localparam logic [31:0] A_CL = {24'h00_0000, OFS_EVENT_CLEAR};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, usb_irq, bus_suspended;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd, w, g;
  logic [1:0] htrans = 2'b00;
  logic go = 1'b0, se0_on = 1'b0, idle_on = 1'b0, pll_on = 1'b0;
  logic [4:0] pick = 5'h00;
  usbif_evt_t evt;
  usbif_line_t line;
  int mismatches = 0, samples_checked = 0, seed = 32'h28a5, s;
  assign hready = hreadyout;
  initial forever #50 clk = ~clk;
  usbif_core #(.RESET_CYC(RC), .SUSPEND_CYC(SC)) i_usbif_core (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .evt(evt), .line(line), .usb_irq(usb_irq), .bus_suspended(bus_suspended));
  usbif_host_model i_usbif_host_model (.clk(clk), .go(go), .pick(pick), .se0_on(se0_on),
    .idle_on(idle_on), .pll_on(pll_on), .evt(evt), .line(line));
  // ----------------------------------------
  // expectation tables, index is the evt bit
  // ----------------------------------------
  function automatic int sbit(input int i);
    if (i >= 10) return i + 7;
    if (i >= 6) return i + 2;
    if (i >= 2) return i - 2;
    return 26;
  endfunction
  function automatic logic [31:0] gate(input int i);
    if (i == 1) return 32'h4000_0000;
    if (i >= 6 && i <= 9) return 32'h2000_0010;
    if (i >= 2 && i <= 5) return 32'h0000_0001 << (i - 2);
    if (i >= 12 && i <= 16) return 32'h2000_0000;
    return 32'h0000_0000;
  endfunction
  // ----------------------------------------
  // bus and event tasks
  // ----------------------------------------
  task automatic xfer(input logic wrt, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wrt;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    // taken at the edge that ends the data phase, before the design updates
    rd = hrdata;
  endtask
  task automatic look(input logic [31:0] es, input logic ei);
    xfer(1'b0, A_ST, 32'h0000_0000);
    `CHK("status", es, rd)
    `CHK("usb_irq", ei, usb_irq)
  endtask
  task automatic ev(input logic [4:0] i);
    pick <= i;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    look(RST_EVENT_STATUS, 1'b0);
    xfer(1'b0, A_EN, 32'h0000_0000);
    `CHK("enable", RST_IRQ_ENABLE, rd)
    w = $random(seed);
    xfer(1'b1, A_EN, w);
    xfer(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    xfer(1'b0, A_EN, 32'h0000_0000);
    `CHK("enable", w & EN_MASK, rd)
    xfer(1'b0, 32'h0000_0100, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    `CHK("hresp", 1'b0, hresp)
    xfer(1'b0, A_CL, 32'h0000_0000);
    `CHK("clear", 32'h0000_0000, rd)
    $display("test registers done");
    for (int i = 1; i < 18; i++) begin
      g = gate(i);
      s = sbit(i);
      // silent flags meet every enable, so a leak into the irq shows
      xfer(1'b1, A_EN, (g == 0) ? EN_MASK : g & (~g + 32'h0000_0001));
      ev(i[4:0]);
      look(32'h0000_0001 << s, g != 0);
      xfer(1'b1, A_EN, EN_MASK & ~g);
      look(32'h0000_0001 << s, 1'b0);
      xfer(1'b1, A_CL, $random(seed) & ~(32'h0000_0001 << s));
      look(32'h0000_0001 << s, 1'b0);
      xfer(1'b1, A_CL, 32'h0000_0001 << s);
      look(32'h0000_0000, 1'b0);
    end
    $display("test events done");
    xfer(1'b1, A_EN, 32'h8000_0000);
    for (int n = RC; n <= RC + 1; n++) begin
      se0_on <= 1'b1;
      repeat (n) @(posedge clk);
      se0_on <= 1'b0;
      repeat (3) @(posedge clk);
      look({n > RC, 31'h0000_0000}, n > RC);
    end
    xfer(1'b1, A_CL, 32'h8000_0000);
    idle_on <= 1'b1;
    repeat (SC + 4) @(posedge clk);
    `CHK("suspended", 1'b1, bus_suspended)
    look(32'h4000_0000, 1'b1);
    idle_on <= 1'b0;
    pll_on <= 1'b1;
    xfer(1'b1, A_EN, 32'h1000_0000);
    look(32'h0000_0000, 1'b0);
    ev(5'h00);
    look(32'h2200_0000, 1'b1);
    xfer(1'b1, A_EN, 32'h8000_0000);
    look(32'h2200_0000, 1'b1);
    `CHK("suspended", 1'b0, bus_suspended)
    xfer(1'b1, A_CL, 32'h2200_0000);
    look(32'h0000_0000, 1'b0);
    $display("test line events done");
    report_and_stop();
  end
endmodule // tb
bind usbif_core usbif_core_assertions #(.SUSPEND_CYC(SUSPEND_CYC)) i_usbif_core_assertions (
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .evt(evt),
  .line(line), .usb_irq(usb_irq), .bus_suspended(bus_suspended));

/* usbif_core.sv */
// usb device interrupt enable and sticky event status with ahb-lite slave
// assumes event pulses and line levels from the serial engine, synchronous to clk
`timescale 1ns/1ps
module usbif_core import usbif_pkg::*; #(
  parameter int RESET_CYC = RESET_SE0_CYC,
  parameter int SUSPEND_CYC = SUSPEND_IDLE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire usbif_evt_t evt,
  input wire usbif_line_t line,
  output logic usb_irq,
  output logic bus_suspended
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (SUSPEND_CYC <= RESET_CYC) begin : g_bad_counts
    $error("usbif_core: suspend count must exceed reset count");
  end

  // ----------------------------------------
  // line duration detectors
  // ----------------------------------------
  logic reset_hit;
  logic suspend_hit;

  usbif_dur_det #(.LIMIT(RESET_CYC)) u_reset_det (
    .clk(clk),
    .sys_rst(sys_rst),
    .cond(line.se0),
    .hit(reset_hit)
  );

  usbif_dur_det #(.LIMIT(SUSPEND_CYC)) u_suspend_det (
    .clk(clk),
    .sys_rst(sys_rst),
    .cond(line.idle),
    .hit(suspend_hit)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [31:0] en,
                                           input logic [31:0] sts);
    read_mux = 32'h0000_0000;
    unique case (a)
      OFS_IRQ_ENABLE: read_mux = en & EN_MASK;
      OFS_EVENT_STATUS: read_mux = sts & STS_MASK;
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic enabled_pending(input logic [31:0] en, input logic [31:0] sts);
    logic bus_g;
    logic gen_g;
    logic ack_g;
    logic nak_g;
    bus_g = en[EN_BUS] & (sts[ST_RESET] | sts[ST_SUSPEND] | sts[ST_RESUME]);
    // setup token, setup error and timeout are left out on purpose
    gen_g = en[EN_GEN] & (sts[ST_SETUP_DONE] | sts[ST_IN_ACK] | sts[ST_OUT_ACK]
                          | sts[ST_IN_STALL] | sts[ST_OUT_STALL]);
    ack_g = (en[EN_EPACK] | en[EN_GEN]) & (|sts[ST_ACK_LO +: NUM_EP]);
    nak_g = |(en[EN_NAK_LO +: NUM_EP] & sts[ST_NAK_LO +: NUM_EP]);
    enabled_pending = bus_g | gen_g | ack_g | nak_g
                      | (en[EN_SOF] & sts[ST_SOF])
                      | (en[EN_WAKE] & sts[ST_WAKE]);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  usbif_st_t st_ff;
  usbif_st_t nxt_st;

  logic addr_take;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic resume_ok;

  assign addr_take = hsel & htrans[1] & hready;
  assign resume_ok = evt.resume_sig & st_ff.suspended;

  // ----------------------------------------
  // event set and software clear vectors
  // ----------------------------------------
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[ST_RESET] = reset_hit;
    set_vec[ST_SUSPEND] = suspend_hit;
    set_vec[ST_RESUME] = resume_ok;
    set_vec[ST_SOF] = evt.sof;
    set_vec[ST_WAKE] = resume_ok & line.pll_off;
    set_vec[ST_SETUP_TOKEN] = evt.setup_token;
    set_vec[ST_SETUP_DONE] = evt.setup_done;
    set_vec[ST_IN_ACK] = evt.in_ack;
    set_vec[ST_OUT_ACK] = evt.out_ack;
    set_vec[ST_IN_STALL] = evt.in_stall;
    set_vec[ST_OUT_STALL] = evt.out_stall;
    set_vec[ST_SETUP_ERR] = evt.setup_err;
    set_vec[ST_TIMEOUT] = evt.timeout;
    set_vec[ST_ACK_LO +: NUM_EP] = evt.ep_ack;
    set_vec[ST_NAK_LO +: NUM_EP] = evt.ep_nak;
    clr_vec = 32'h0000_0000;
    if (st_ff.wr_pend && st_ff.wr_addr == OFS_EVENT_CLEAR) begin
      // suspend has no clear bit; it follows the line instead
      clr_vec = hwdata & STS_MASK;
      clr_vec[ST_SUSPEND] = 1'b0;
    end
    if (line.idle == 1'b0) begin
      clr_vec[ST_SUSPEND] = 1'b1;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr_pend = 1'b0;
    if (st_ff.wr_pend && st_ff.wr_addr == OFS_IRQ_ENABLE) begin
      nxt_st.en = hwdata & EN_MASK;
    end
    // set wins over a clear landing in the same cycle
    nxt_st.sts = ((st_ff.sts & ~clr_vec) | set_vec) & STS_MASK;
    if (suspend_hit) begin
      nxt_st.suspended = 1'b1;
    end else if (resume_ok || reset_hit) begin
      nxt_st.suspended = 1'b0;
    end
    if (addr_take) begin
      nxt_st.wr_pend = hwrite;
      nxt_st.wr_addr = haddr[7:0];
      // read sees any write finishing in this same cycle
      nxt_st.rdata = hwrite ? 32'h0000_0000 : read_mux(haddr[7:0], nxt_st.en, nxt_st.sts);
    end
    nxt_st.irq = enabled_pending(nxt_st.en, nxt_st.sts);
    if (haddr[31:8] != 24'h00_0000 && addr_take) begin
      // out-of-window addresses read zero and drop writes
      nxt_st.wr_addr = 8'hFF;
      nxt_st.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff.en <= RST_IRQ_ENABLE;
      st_ff.sts <= RST_EVENT_STATUS;
      st_ff.suspended <= 1'b0;
      st_ff.irq <= 1'b0;
      st_ff.wr_pend <= 1'b0;
      st_ff.wr_addr <= 8'h00;
      st_ff.rdata <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero wait states, so the slave never stretches a transfer
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign usb_irq = st_ff.irq;
  assign bus_suspended = st_ff.suspended;

endmodule // usbif_core

/* usbif_core_assertions.sv */
// port checker for usbif_core: bus readback, irq gating, suspend timing
// assumes binding onto usbif_core, one clock, synchronous active high reset
`timescale 1ns/1ps
module usbif_core_assertions import usbif_pkg::*; #(
  parameter int SUSPEND_CYC = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire usbif_evt_t evt,
  input wire usbif_line_t line,
  input wire logic usb_irq,
  input wire logic bus_suspended
);
  // ----------------------------------------
  // helpers: enable shadow snooped off the bus
  // ----------------------------------------
  logic [31:0] en_ff;
  logic wr_ff, en_wr_ff, en_rd_ff, sts_rd_ff;
  logic [15:0] idle_ff;
  logic [17:0] ev;
  logic take, at_en, at_st;
  assign ev = evt;
  assign take = hsel && htrans[1] && hready && haddr[31:8] == 24'h00_0000;
  assign at_en = take && haddr[7:0] == OFS_IRQ_ENABLE;
  assign at_st = take && haddr[7:0] == OFS_EVENT_STATUS;
  always_ff @(posedge clk) begin
    wr_ff <= !sys_rst && hsel && htrans[1] && hready && hwrite;
    en_wr_ff <= !sys_rst && at_en && hwrite;
    en_rd_ff <= !sys_rst && at_en && !hwrite;
    sts_rd_ff <= !sys_rst && at_st && !hwrite;
    en_ff <= sys_rst ? 32'h0000_0000 : en_wr_ff ? hwdata & EN_MASK : en_ff;
    // saturates so a long idle never wraps back under the limit
    idle_ff <= (sys_rst || !line.idle) ? 16'h0000 : idle_ff + {15'h0000, idle_ff != 16'hFFFF};
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  en_readback_a: assert property (en_rd_ff |-> hrdata == en_ff)
    else $error("enable readback wrong");
  sts_reserved_a: assert property (sts_rd_ff |-> (hrdata & ~STS_MASK) == 32'h0000_0000)
    else $error("reserved status bit set");
  irq_needs_en_a: assert property (en_ff == 32'h0000_0000 |-> !usb_irq)
    else $error("irq with all enables off");
  sof_irq_a: assert property (evt.sof && en_ff[EN_SOF] && !wr_ff |=> usb_irq)
    else $error("frame start gave no irq");
  gen_irq_a: assert property ((|ev[16:12]) && en_ff[EN_GEN] && !wr_ff |=> usb_irq)
    else $error("general event gave no irq");
  ack_irq_a: assert property ((|evt.ep_ack) && en_ff[EN_EPACK] && !wr_ff |=> usb_irq)
    else $error("endpoint ack gave no irq");
  nak_irq_a: assert property ((|(evt.ep_nak & en_ff[3:0])) && !wr_ff |=> usb_irq)
    else $error("enabled nak gave no irq");
  quiet_flags_a: assert property (
    !usb_irq && (ev & 18'h1_F3FF) == 18'h0_0000 && !wr_ff
    && !line.se0 && !line.idle && !$past(line.se0) && !$past(line.idle) |=> !usb_irq)
    else $error("silent flag raised irq");
  suspend_time_a: assert property (idle_ff >= SUSPEND_CYC + 2 |-> bus_suspended)
    else $error("long idle not suspended");
endmodule // usbif_core_assertions

/* usbif_dur_det.sv */
// duration detector: one-cycle pulse once a level has held longer than a limit
// assumes cond is synchronous to clk
`timescale 1ns/1ps
module usbif_dur_det import usbif_pkg::*; #(
  parameter int LIMIT = 25
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cond,
  output logic hit
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (LIMIT < 1 || LIMIT >= (2 ** DET_CNT_W) - 1) begin : g_bad_limit
    $error("usbif_dur_det: LIMIT out of range");
  end

  localparam logic [DET_CNT_W-1:0] LIM = DET_CNT_W'(LIMIT);
  localparam logic [DET_CNT_W-1:0] TOP = DET_CNT_W'(LIMIT + 1);

  usbif_det_st_t st_ff;
  usbif_det_st_t nxt_st;

  // ----------------------------------------
  // count while the level holds
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.hit = 1'b0;
    if (!cond) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt != TOP) begin
      // saturate so a long level fires only once
      nxt_st.cnt = st_ff.cnt + 1'b1;
      nxt_st.hit = (st_ff.cnt == LIM);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hit = st_ff.hit;

endmodule // usbif_dur_det

/* usbif_host_model.sv */
// host-side stand-in: one-cycle event pulses and bus line levels
// assumes requests from tb on clk edges; se0 overrides idle as on the wire
`timescale 1ns/1ps
module usbif_host_model import usbif_pkg::*; (
  input wire logic clk,
  input wire logic go,
  input wire logic [4:0] pick,
  input wire logic se0_on,
  input wire logic idle_on,
  input wire logic pll_on,
  output usbif_evt_t evt,
  output usbif_line_t line
);
  always_ff @(posedge clk) begin
    evt <= usbif_evt_t'(go ? 18'h0_0001 << pick : 18'h0_0000);
    line <= {se0_on, idle_on && !se0_on, pll_on};
  end
endmodule // usbif_host_model

/* usbif_pkg.sv */
// usb interrupt enable / event status package
// assumes a single 10 MHz system clock and an ahb-lite register bus
package usbif_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h04;
  localparam logic [7:0] OFS_EVENT_CLEAR = 8'h08;
  localparam logic [31:0] RST_IRQ_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_EVENT_STATUS = 32'h0000_0000;
  localparam logic [31:0] EN_MASK = 32'hF000_001F;
  localparam logic [31:0] STS_MASK = 32'hE7FE_0F0F;

  // ----------------------------------------
  // enable bit positions
  // ----------------------------------------
  localparam int EN_BUS = 31;
  localparam int EN_SOF = 30;
  localparam int EN_GEN = 29;
  localparam int EN_WAKE = 28;
  localparam int EN_EPACK = 4;
  localparam int EN_NAK_LO = 0;

  // ----------------------------------------
  // status bit positions
  // ----------------------------------------
  localparam int ST_RESET = 31;
  localparam int ST_SUSPEND = 30;
  localparam int ST_RESUME = 29;
  localparam int ST_SOF = 26;
  localparam int ST_WAKE = 25;
  localparam int ST_SETUP_TOKEN = 24;
  localparam int ST_SETUP_DONE = 23;
  localparam int ST_IN_ACK = 22;
  localparam int ST_OUT_ACK = 21;
  localparam int ST_IN_STALL = 20;
  localparam int ST_OUT_STALL = 19;
  localparam int ST_SETUP_ERR = 18;
  localparam int ST_TIMEOUT = 17;
  localparam int ST_ACK_LO = 8;
  localparam int ST_NAK_LO = 0;
  localparam int NUM_EP = 4;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_SE0_NS = 2500;
  localparam int SUSPEND_IDLE_US = 3;
  localparam int SUSPEND_IDLE_MS = SUSPEND_IDLE_US;
  localparam int RESET_SE0_CYC = (RESET_SE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUSPEND_IDLE_CYC = (SUSPEND_IDLE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int DET_CNT_W = 16;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic setup_token;
    logic setup_done;
    logic in_ack;
    logic out_ack;
    logic in_stall;
    logic out_stall;
    logic setup_err;
    logic timeout;
    logic [NUM_EP-1:0] ep_ack;
    logic [NUM_EP-1:0] ep_nak;
    logic sof;
    logic resume_sig;
  } usbif_evt_t;

  typedef struct packed {
    logic se0;
    logic idle;
    logic pll_off;
  } usbif_line_t;

  typedef struct packed {
    logic [DET_CNT_W-1:0] cnt;
    logic hit;
  } usbif_det_st_t;

  typedef struct packed {
    logic [31:0] en;
    logic [31:0] sts;
    logic suspended;
    logic irq;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } usbif_st_t;

endpackage
